// ### bmad_pkg.sv
// constants, types and helpers for the banked memory address decoder
// assumes one 25 MHz system clock and a core on the same clock
package bmad_pkg;

    localparam int          PC_W         = 13;
    localparam int          DADDR_W      = 9;
    localparam logic [12:0] PC_RESET_VEC = 13'h0000;
    localparam logic [12:0] PC_IRQ_VEC   = 13'h0004;
    localparam logic [12:0] PC_TOP_2K    = 13'h07FF;
    localparam logic [12:0] PC_TOP_4K    = 13'h0FFF;
    localparam logic [12:0] PC_TOP_8K    = 13'h1FFF;

    localparam logic [6:0]  OFS_INDIRECT = 7'h00;
    localparam logic [6:0]  OFS_PC_LOW   = 7'h02;
    localparam logic [6:0]  OFS_STATUS   = 7'h03;
    localparam logic [6:0]  OFS_POINTER  = 7'h04;
    localparam logic [6:0]  OFS_PC_HIGH  = 7'h0A;
    localparam logic [6:0]  OFS_BANK_TOP = 7'h7F;

    localparam logic [6:0]  GPR_LO_B01   = 7'h20;
    localparam logic [6:0]  GPR_LO_B23   = 7'h10;
    localparam logic [6:0]  MIRROR_LO    = 7'h70;

    localparam int          BANK_HI_BIT  = 6;
    localparam int          BANK_LO_BIT  = 5;
    localparam int          IND_BANK_BIT = 7;

    localparam logic [7:0]  STATUS_RST   = 8'h00;
    localparam logic [7:0]  POINTER_RST  = 8'h00;
    localparam logic [7:0]  PC_HIGH_RST  = 8'h00;
    localparam logic [7:0]  DATA_ZERO    = 8'h00;

    typedef enum logic [1:0] {BMAD_Q1, BMAD_Q2, BMAD_Q3, BMAD_Q4} bmad_phase_t;
    typedef enum logic [2:0] {BMAD_SEL_IND, BMAD_SEL_PC_LOW, BMAD_SEL_STATUS, BMAD_SEL_POINTER,
                              BMAD_SEL_PC_HIGH, BMAD_SEL_PERIPH, BMAD_SEL_GPR} bmad_sel_t;

    // lowest general purpose offset of a bank
    function automatic logic [6:0] bmad_gpr_lo(input logic [1:0] bank);
        bmad_gpr_lo = bank[1] ? GPR_LO_B23 : GPR_LO_B01;
    endfunction : bmad_gpr_lo

endpackage : bmad_pkg

// ### bmad_mem_if.sv
// carrier between the decoder and its general purpose ram
// assumes both ends run on sys_clk
`timescale 1ns/1ps
interface bmad_mem_if;
    logic [8:0] addr;
    logic       wr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       hit;

    modport ctrl (output addr, output wr, output wdata, input rdata, input hit);
    modport ram  (input addr, input wr, input wdata, output rdata, output hit);
endinterface : bmad_mem_if

// ### bmad_gpr_ram.sv
// general purpose static ram of all four banks, with the common area mirror
// assumes the controller gives a 9 bit bank:offset address
`timescale 1ns/1ps
module bmad_gpr_ram
    import bmad_pkg::*;
(
    input  wire logic sys_clk,
    bmad_mem_if.ram   mem
);

    logic [7:0] store [0:511];
    logic [8:0] phys;
    logic       in_gpr;

    // --------------------------------------------------------------
    // address map
    // --------------------------------------------------------------
    always_comb
    begin
        in_gpr = mem.addr[6:0] >= bmad_gpr_lo(mem.addr[8:7]);
        if (mem.addr[6:0] >= MIRROR_LO)
        begin
            phys = {2'b00, mem.addr[6:0]};
        end
        else
        begin
            phys = mem.addr;
        end
    end

    assign mem.hit   = in_gpr;
    assign mem.rdata = in_gpr ? store[phys] : DATA_ZERO;

    // --------------------------------------------------------------
    // storage
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (mem.wr && in_gpr)
        begin
            store[phys] <= mem.wdata;
        end
    end

endmodule : bmad_gpr_ram

// ### bmad_decoder.sv
// program counter and banked data memory decoder of the processor core
// assumes core request inputs are on sys_clk and steady through an instruction cycle
`timescale 1ns/1ps
module bmad_decoder
    import bmad_pkg::*;
#(
    parameter logic [12:0] PROG_TOP = PC_TOP_8K
)
(
    input  wire logic                        sys_clk,
    input  wire logic                        rst_n,
    input  wire logic [6:0]                  op_offset,
    input  wire logic                        op_read,
    input  wire logic                        op_write,
    input  wire logic [7:0]                  op_wdata,
    input  wire logic                        pc_jump,
    input  wire logic [10:0]                 jump_target,
    input  wire logic                        irq_take,
    input  wire logic [7:0]                  periph_rdata,
    output logic      [bmad_pkg::PC_W-1:0]   fetch_addr,
    output bmad_pkg::bmad_phase_t            q_phase,
    output logic      [7:0]                  rd_data,
    output logic      [7:0]                  status_out,
    output logic      [bmad_pkg::DADDR_W-1:0] periph_addr,
    output logic                             periph_rd,
    output logic                             periph_wr,
    output logic      [7:0]                  periph_wdata
);
    import bmad_pkg::*;

    bmad_mem_if mem ();

    bmad_gpr_ram u_ram
    (
        .sys_clk (sys_clk),
        .mem     (mem)
    );

    logic [7:0]  processor_status;
    logic [7:0]  file_select_pointer;
    logic [7:0]  program_counter_high_latch;
    logic [7:0]  next_processor_status;
    logic [7:0]  next_file_select_pointer;
    logic [7:0]  next_program_counter_high_latch;
    logic [12:0] next_pc;
    logic [7:0]  next_rd_data;
    logic [8:0]  next_periph_addr;
    logic        next_periph_rd;
    logic        next_periph_wr;
    logic [7:0]  next_periph_wdata;
    bmad_phase_t next_phase;
    logic [8:0]  eff_addr;
    bmad_sel_t   sel;
    logic [7:0]  sel_rdata;

    // pc and wrap mask
    function automatic logic [12:0] bmad_wrap(input logic [12:0] a);
        bmad_wrap = a & PROG_TOP;
    endfunction : bmad_wrap

    // special register decode of one offset
    function automatic bmad_sel_t bmad_decode(input logic [8:0] a);
        case (a[6:0])
            OFS_INDIRECT: bmad_decode = BMAD_SEL_IND;
            OFS_PC_LOW:   bmad_decode = BMAD_SEL_PC_LOW;
            OFS_STATUS:   bmad_decode = BMAD_SEL_STATUS;
            OFS_POINTER:  bmad_decode = BMAD_SEL_POINTER;
            OFS_PC_HIGH:  bmad_decode = BMAD_SEL_PC_HIGH;
            default:
            begin
                if (a[6:0] >= bmad_gpr_lo(a[8:7]))
                begin
                    bmad_decode = BMAD_SEL_GPR;
                end
                else
                begin
                    bmad_decode = BMAD_SEL_PERIPH;
                end
            end
        endcase
    endfunction : bmad_decode

    // --------------------------------------------------------------
    // address formation
    // --------------------------------------------------------------
    always_comb
    begin
        if (op_offset == OFS_INDIRECT)
        begin
            eff_addr = {processor_status[IND_BANK_BIT], file_select_pointer};
        end
        else
        begin
            eff_addr = {processor_status[BANK_HI_BIT], processor_status[BANK_LO_BIT],
                        op_offset};
        end
        sel = bmad_decode(eff_addr);
        case (sel)
            BMAD_SEL_PC_LOW:  sel_rdata = fetch_addr[7:0];
            BMAD_SEL_STATUS:  sel_rdata = processor_status;
            BMAD_SEL_POINTER: sel_rdata = file_select_pointer;
            BMAD_SEL_PC_HIGH: sel_rdata = program_counter_high_latch;
            BMAD_SEL_PERIPH:  sel_rdata = periph_rdata;
            BMAD_SEL_GPR:     sel_rdata = mem.hit ? mem.rdata : DATA_ZERO;
            default:          sel_rdata = DATA_ZERO;
        endcase
    end

    assign mem.addr  = eff_addr;
    assign mem.wdata = op_wdata;
    assign mem.wr    = (q_phase == BMAD_Q4) && op_write && (sel == BMAD_SEL_GPR);

    // --------------------------------------------------------------
    // phase, program counter and register next values
    // --------------------------------------------------------------
    always_comb
    begin
        next_phase        = bmad_phase_t'(q_phase + 2'd1);
        next_pc           = fetch_addr;
        next_processor_status           = processor_status;
        next_file_select_pointer        = file_select_pointer;
        next_program_counter_high_latch = program_counter_high_latch;
        next_rd_data      = rd_data;
        next_periph_addr  = eff_addr;
        next_periph_rd    = 1'b0;
        next_periph_wr    = 1'b0;
        next_periph_wdata = op_wdata;
        case (q_phase)
            BMAD_Q1:
            begin
                if (irq_take)
                begin
                    next_pc = bmad_wrap(PC_IRQ_VEC);
                end
                else if (pc_jump)
                begin
                    next_pc = bmad_wrap({program_counter_high_latch[4:3], jump_target});
                end
                else
                begin
                    next_pc = bmad_wrap(fetch_addr + 13'h0001);
                end
                next_periph_rd = op_read && (sel == BMAD_SEL_PERIPH);
            end
            BMAD_Q2:
            begin
                if (op_read)
                begin
                    next_rd_data = sel_rdata;
                end
            end
            BMAD_Q3:
            begin
                next_periph_wr = op_write && (sel == BMAD_SEL_PERIPH);
            end
            BMAD_Q4:
            begin
                if (op_write)
                begin
                    case (sel)
                        BMAD_SEL_PC_LOW:
                        begin
                            next_pc = bmad_wrap({program_counter_high_latch[4:0],
                                                 op_wdata});
                        end
                        BMAD_SEL_STATUS:  next_processor_status = op_wdata;
                        BMAD_SEL_POINTER: next_file_select_pointer = op_wdata;
                        BMAD_SEL_PC_HIGH: next_program_counter_high_latch = op_wdata;
                        default:          next_processor_status = processor_status;
                    endcase
                end
            end
            default:
            begin
                next_phase = BMAD_Q1;
            end
        endcase
    end

    // --------------------------------------------------------------
    // state registers
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q_phase      <= BMAD_Q1;
            fetch_addr   <= PC_RESET_VEC;
            processor_status           <= STATUS_RST;
            file_select_pointer        <= POINTER_RST;
            program_counter_high_latch <= PC_HIGH_RST;
            rd_data      <= DATA_ZERO;
            status_out   <= STATUS_RST;
            periph_addr  <= 9'h000;
            periph_rd    <= 1'b0;
            periph_wr    <= 1'b0;
            periph_wdata <= DATA_ZERO;
        end
        else
        begin
            q_phase      <= next_phase;
            fetch_addr   <= next_pc;
            processor_status           <= next_processor_status;
            file_select_pointer        <= next_file_select_pointer;
            program_counter_high_latch <= next_program_counter_high_latch;
            rd_data      <= next_rd_data;
            status_out   <= next_processor_status;
            periph_addr  <= next_periph_addr;
            periph_rd    <= next_periph_rd;
            periph_wr    <= next_periph_wr;
            periph_wdata <= next_periph_wdata;
        end
    end

endmodule : bmad_decoder

// ### bmad_decoder_props.sv
// checker of decoder phase timing, program counter and address forming
// assumes a bind onto bmad_decoder, whose ports it watches
`timescale 1ns/1ps
module bmad_decoder_props
    import bmad_pkg::*;
#(
    parameter logic [12:0] PROG_TOP = PC_TOP_8K
)
(
    input logic                  sys_clk,
    input logic                  rst_n,
    input logic [6:0]            op_offset,
    input logic                  op_read,
    input logic                  op_write,
    input logic [7:0]            op_wdata,
    input logic                  pc_jump,
    input logic                  irq_take,
    input logic [12:0]           fetch_addr,
    input bmad_pkg::bmad_phase_t q_phase,
    input logic [7:0]            rd_data,
    input logic [7:0]            status_out,
    input logic [8:0]            periph_addr,
    input logic                  periph_rd,
    input logic                  periph_wr,
    input logic [7:0]            periph_wdata
);
    // ----------
    // properties
    // ----------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_quad;
        q_phase == BMAD_Q1 ##1 q_phase == BMAD_Q2 ##1 q_phase == BMAD_Q3 ##1 q_phase == BMAD_Q4;
    endsequence
    property p_phase;
        q_phase == BMAD_Q1 |-> s_quad;
    endproperty
    a_phase: assert property (p_phase) else $error("phase order");
    property p_wrap;
        (fetch_addr & ~PROG_TOP) == 13'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pc above top");
    property p_inc;
        q_phase == BMAD_Q1 && !irq_take && !pc_jump
            |=> fetch_addr == (($past(fetch_addr) + 13'h0001) & PROG_TOP);
    endproperty
    a_inc: assert property (p_inc) else $error("pc step");
    property p_irq;
        q_phase == BMAD_Q1 && irq_take |=> fetch_addr == PC_IRQ_VEC;
    endproperty
    a_irq: assert property (p_irq) else $error("irq vector");
    property p_rd;
        periph_rd |-> q_phase == BMAD_Q2 && op_read;
    endproperty
    a_rd: assert property (p_rd) else $error("read phase");
    property p_wr;
        periph_wr |-> q_phase == BMAD_Q4 && op_write && periph_wdata == op_wdata;
    endproperty
    a_wr: assert property (p_wr) else $error("write phase");
    property p_hold;
        !$stable(rd_data) |-> q_phase == BMAD_Q3;
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_bank;
        q_phase == BMAD_Q2 && op_offset != OFS_INDIRECT
            |-> periph_addr == {status_out[6:5], op_offset};
    endproperty
    a_bank: assert property (p_bank) else $error("bank address");
endmodule : bmad_decoder_props

bind bmad_decoder bmad_decoder_props #(.PROG_TOP(PROG_TOP)) u_props (
    .sys_clk, .rst_n, .op_offset, .op_read, .op_write, .op_wdata, .pc_jump, .irq_take,
    .fetch_addr, .q_phase, .rd_data, .status_out, .periph_addr, .periph_rd, .periph_wr,
    .periph_wdata);

// ### bmad_periph_model.sv
// peripheral register model on the decoder's peripheral port
// assumes strobes of one sys_clk cycle from the decoder
`timescale 1ns/1ps
module bmad_periph_model
    import bmad_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic [8:0] periph_addr,
    input  wire logic       periph_rd,
    input  wire logic       periph_wr,
    input  wire logic [7:0] periph_wdata,
    output logic      [7:0] periph_rdata
);
    // -------------
    // register store
    // -------------
    logic [7:0] regs [512];
    logic [7:0] last = 8'h00;
    initial foreach (regs[i]) regs[i] = DATA_ZERO;
    always @(posedge sys_clk)
    begin
        if (periph_wr) regs[periph_addr] <= periph_wdata;
        if (periph_rd) last <= regs[periph_addr];
    end
    // unselected port shows the inverse of the last answer
    assign periph_rdata = periph_rd ? regs[periph_addr] : ~last;
endmodule : bmad_periph_model

// ### testbench.sv
// self-checking bench of the banked memory address decoder
// assumes package, decoder, ram, checker and peripheral model compiled first
`timescale 1ns/1ps
module testbench;
    import bmad_pkg::*;
    typedef struct packed {logic [6:0] ofs; logic wr; logic [7:0] wd; logic [7:0] ex;} bmad_row_t;
    logic        sys_clk = 1'b0, rst_n = 1'b0, op_read = 1'b0, op_write = 1'b0;
    logic        pc_jump = 1'b0, irq_take = 1'b0, periph_rd, periph_wr;
    logic [6:0]  op_offset = 7'h00;
    logic [7:0]  op_wdata = 8'h00, periph_rdata, rd_data, status_out, periph_wdata;
    logic [10:0] jump_target = 11'h000;
    logic [12:0] fetch_addr;
    logic [8:0]  periph_addr;
    bmad_phase_t q_phase;
    int          err_total = 0, cmp_count = 0;
    // offset, write flag, write data, expected read
    bmad_row_t   rows [21] = '{24'h070000, 24'h411111, 24'h092020, 24'h013333,
        24'h400033, 24'h072020, 24'h414444, 24'hE15555, 24'h080020,
        24'h074040, 24'h216666, 24'hE00055, 24'hFF7777, 24'h076060,
        24'h231212, 24'h070000, 24'h400033, 24'hFE0077, 24'h0BA5A5,
        24'h090000, 24'h019900};
    bmad_decoder #(.PROG_TOP(PC_TOP_4K)) dut (.sys_clk, .rst_n, .op_offset, .op_read,
        .op_write, .op_wdata, .pc_jump, .jump_target, .irq_take, .periph_rdata, .fetch_addr,
        .q_phase, .rd_data, .status_out, .periph_addr, .periph_rd, .periph_wr, .periph_wdata);
    bmad_periph_model u_periph (.sys_clk, .periph_addr, .periph_rd, .periph_wr,
        .periph_wdata, .periph_rdata);
    initial forever #20 sys_clk = ~sys_clk;
    // ------------
    // bench tasks
    // ------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] want);
        cmp_count++;
        if (got !== want)
        begin
            err_total++;
            $display("unexpected at %0t: data %h, want %h", $time, got, want);
        end
    endtask : chk8
    task automatic chk13(input logic [12:0] got, input logic [12:0] want);
        cmp_count++;
        if (got !== want)
        begin
            err_total++;
            $display("unexpected at %0t: pc %h, want %h", $time, got, want);
        end
    endtask : chk13
    // one instruction cycle, entered at the falling edge inside phase one
    task automatic exec(input logic [6:0] ofs, input logic rd, input logic wr,
                        input logic [7:0] wd);
        op_offset = ofs;
        op_read = rd;
        op_write = wr;
        op_wdata = wd;
        repeat (4) @(negedge sys_clk);
    endtask : exec
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    initial
    begin
        repeat (3000) @(posedge sys_clk);
        err_total++;
        final_report();
    end
    initial
    begin
        repeat (5) @(negedge sys_clk);
        chk13(fetch_addr, PC_RESET_VEC);
        rst_n = 1'b1;
        foreach (rows[i])
        begin
            if (rows[i].wr) exec(rows[i].ofs, 1'b0, 1'b1, rows[i].wd);
            exec(rows[i].ofs, 1'b1, 1'b0, 8'h00);
            chk8(rd_data, rows[i].ex);
        end
        irq_take = 1'b1;
        exec(7'h20, 1'b0, 1'b0, 8'h00);
        irq_take = 1'b0;
        chk13(fetch_addr, PC_IRQ_VEC);
        exec(7'h20, 1'b0, 1'b0, 8'h00);
        chk13(fetch_addr, 13'h0005);
        exec(OFS_PC_HIGH, 1'b0, 1'b1, 8'h18);
        pc_jump = 1'b1;
        jump_target = 11'h7FF;
        exec(7'h20, 1'b0, 1'b0, 8'h00);
        pc_jump = 1'b0;
        chk13(fetch_addr, PC_TOP_4K);
        exec(7'h20, 1'b0, 1'b0, 8'h00);
        chk13(fetch_addr, PC_RESET_VEC);
        exec(OFS_PC_LOW, 1'b0, 1'b1, 8'h34);
        chk13(fetch_addr, 13'h0834);
        rst_n = 1'b0;
        @(negedge sys_clk);
        chk13(fetch_addr, PC_RESET_VEC);
        chk8(status_out, STATUS_RST);
        rst_n = 1'b1;
        exec(OFS_STATUS, 1'b1, 1'b0, 8'h00);
        chk8(rd_data, STATUS_RST);
        final_report();
    end
endmodule : testbench
